// [hw/exec_core_defs.vh]
`ifndef EXEC_CORE_DEFS_VH
`define EXEC_CORE_DEFS_VH

// =====================================================
// Register byte offsets
`define OFS_CMD 12'h000
`define OFS_OPERAND 12'h004
`define OFS_REPLY_STATUS 12'h008
`define OFS_REPLY_VALUE 12'h00C
`define OFS_ACCUM 12'h010
`define OFS_PC 12'h014
`define OFS_FLAGS 12'h018
`define OFS_OUTPUTS 12'h01C
`define OFS_IRQ_STATUS 12'h020
`define OFS_IRQ_CLEAR 12'h024
`define OFS_IRQ_ENABLE 12'h028
`define OFS_CTRL 12'h02C

// =====================================================
// Command register fields
`define CMD_CODE_LSB 0
`define CMD_TYPE_LSB 8
`define CMD_BANK_LSB 16

// =====================================================
// Instruction codes
`define INSTR_INPUT_READ 8'h0F
`define INSTR_ACCUM_ACCUM_INSTR_A 8'h13
`define INSTR_COMPARE 8'h14
`define INSTR_COND_JUMP 8'h15

// =====================================================
// Calculate operations
`define OP_ADD 8'h00
`define OP_SUB 8'h01
`define OP_MULTIPLY 8'h02
`define OP_DIVIDE 8'h03
`define OP_REMAINDER 8'h04
`define OP_AND 8'h05
`define OP_OR 8'h06
`define OP_XOR 8'h07
`define OP_INVERT 8'h08
`define OP_LOAD 8'h09

// =====================================================
// Jump conditions
`define COND_ZERO 8'h00
`define COND_NONZERO 8'h01
`define COND_EQUAL 8'h02
`define COND_UNEQUAL 8'h03
`define COND_GREATER 8'h04
`define COND_GREATER_EQUAL 8'h05
`define COND_LOWER 8'h06
`define COND_LOWER_EQUAL 8'h07
`define COND_TIMEOUT_ERROR 8'h08
`define COND_EXTERNAL_ALARM 8'h09
`define COND_DEVIATION_ERROR 8'h0A
`define COND_POSITION_ERROR 8'h0B

// =====================================================
// Banks and reply status codes
`define BANK_DIGITAL 8'h00
`define BANK_ANALOG 8'h01
`define BANK_OUTPUT 8'h02
`define STATUS_OK 8'h64
`define STATUS_BAD_TYPE 8'h03
`define STATUS_BAD_VALUE 8'h04
`define STATUS_BAD_CMD 8'h02

// =====================================================
// Interrupt bits, divider step count and reset values
`define IRQ_DONE 0
`define IRQ_ERROR 1
`define IRQ_JUMP 2
`define IRQ_WIDTH 3
`define DIV_STEPS 6'd32
`define RST_WORD 32'h00000000
`endif

// [hw/seq_divider.v]
`timescale 1ns/10ps
`default_nettype none
`include "exec_core_defs.vh"

module seq_divider (
	input wire pclk,
	input wire presetn,
	input wire start,
	input wire [31:0] dividend,
	input wire [31:0] divisor,
	output reg [31:0] quotient_ff,
	output reg [31:0] remainder_ff,
	output reg done_ff
);

	reg [31:0] num_ff;
	reg [31:0] den_ff;
	reg [31:0] rem_ff;
	reg [5:0] cnt_ff;
	reg neg_q_ff;
	reg neg_r_ff;
	reg run_ff;
	wire [32:0] trial;
	wire [31:0] abs_a;
	wire [31:0] abs_b;

	// Magnitudes of the signed operands.
	assign abs_a = dividend[31] ? (~dividend + 32'h00000001) : dividend;
	assign abs_b = divisor[31] ? (~divisor + 32'h00000001) : divisor;
	assign trial = {rem_ff, num_ff[31]} - {1'b0, den_ff};

	// Restoring division, one quotient bit per clock; truncates toward
	// zero and the remainder takes the sign of the dividend.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			num_ff <= `RST_WORD;
			den_ff <= `RST_WORD;
			rem_ff <= `RST_WORD;
			cnt_ff <= 6'h00;
			neg_q_ff <= 1'b0;
			neg_r_ff <= 1'b0;
			run_ff <= 1'b0;
			done_ff <= 1'b0;
			quotient_ff <= `RST_WORD;
			remainder_ff <= `RST_WORD;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				num_ff <= abs_a;
				den_ff <= abs_b;
				rem_ff <= `RST_WORD;
				cnt_ff <= `DIV_STEPS;
				neg_q_ff <= dividend[31] ^ divisor[31];
				neg_r_ff <= dividend[31];
				run_ff <= 1'b1;
			end else if (run_ff) begin
				if (cnt_ff == 6'h00) begin
					run_ff <= 1'b0;
					done_ff <= 1'b1;
					quotient_ff <= neg_q_ff ? (~num_ff + 32'h00000001) : num_ff;
					remainder_ff <= neg_r_ff ? (~rem_ff + 32'h00000001) : rem_ff;
				end else begin
					cnt_ff <= cnt_ff - 6'h01;
					if (!trial[32]) begin
						rem_ff <= trial[31:0];
						num_ff <= {num_ff[30:0], 1'b1};
					end else begin
						rem_ff <= {rem_ff[30:0], num_ff[31]};
						num_ff <= {num_ff[30:0], 1'b0};
					end
				end
			end
		end
	end

endmodule // seq_divider
`default_nettype wire

// [hw/io_read_accumulator_branch_core.v]
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "exec_core_defs.vh"

module io_read_accumulator_branch_core (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire shared_input_0,
	input wire shared_input_1,
	input wire shared_input_2,
	input wire shared_input_3,
	input wire [15:0] adc_value_0,
	input wire [15:0] adc_value_1,
	input wire [15:0] adc_value_2,
	input wire [15:0] adc_value_3,
	input wire err_timeout,
	input wire err_alarm,
	input wire err_deviation,
	input wire err_position,
	output wire gp_output_0,
	output wire gp_output_1,
	output wire gp_output_2,
	output wire gp_output_3,
	output wire irq
);

	// =====================================================
	// State codes
	localparam ST_IDLE = 2'b00;
	localparam ST_EXEC = 2'b01;
	localparam ST_DIV = 2'b10;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [31:0] cmd_ff;
	reg [31:0] operand_ff;
	reg [31:0] accum_ff;
	reg [31:0] nxt_accum;
	reg [31:0] pc_ff;
	reg [31:0] nxt_pc;
	reg [7:0] reply_status_ff;
	reg [7:0] nxt_reply_status;
	reg [31:0] reply_value_ff;
	reg [31:0] nxt_reply_value;
	reg [3:0] cmp_flags_ff;
	reg [3:0] nxt_cmp_flags;
	reg [3:0] outputs_ff;
	reg standalone_ff;
	reg [`IRQ_WIDTH-1:0] irq_status_ff;
	reg [`IRQ_WIDTH-1:0] irq_enable_ff;
	reg [`IRQ_WIDTH-1:0] nxt_event;
	reg [7:0] sync1_ff;
	reg [7:0] sync2_ff;
	reg div_start;
	wire [31:0] div_quotient;
	wire [31:0] div_remainder;
	wire div_done;
	wire wr_en;
	wire rd_en;
	wire [7:0] code;
	wire [7:0] op_type;
	wire [7:0] bank;
	wire [32:0] diff;
	wire [63:0] product;

	// =====================================================
	// Bus side
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign code = cmd_ff[`CMD_CODE_LSB+7:`CMD_CODE_LSB];
	assign op_type = cmd_ff[`CMD_TYPE_LSB+7:`CMD_TYPE_LSB];
	assign bank = cmd_ff[`CMD_BANK_LSB+7:`CMD_BANK_LSB];
	assign gp_output_0 = outputs_ff[0];
	assign gp_output_1 = outputs_ff[1];
	assign gp_output_2 = outputs_ff[2];
	assign gp_output_3 = outputs_ff[3];
	assign irq = |(irq_status_ff & irq_enable_ff);

	// Selects one of four bits by port number.
	function sel_bit;
		input [3:0] bits;
		input [7:0] port;
		begin
			sel_bit = bits[port[1:0]];
		end
	endfunction

	// Tests one jump condition against compare and error flags.
	function cond_met;
		input [7:0] cond;
		input [3:0] cf;
		input [3:0] ef;
		begin
			case (cond)
				`COND_ZERO: cond_met = cf[0];
				`COND_NONZERO: cond_met = ~cf[0];
				`COND_EQUAL: cond_met = cf[1];
				`COND_UNEQUAL: cond_met = ~cf[1];
				`COND_GREATER: cond_met = cf[2];
				`COND_GREATER_EQUAL: cond_met = cf[2] | cf[1];
				`COND_LOWER: cond_met = cf[3];
				`COND_LOWER_EQUAL: cond_met = cf[3] | cf[1];
				`COND_TIMEOUT_ERROR: cond_met = ef[0];
				`COND_EXTERNAL_ALARM: cond_met = ef[1];
				`COND_DEVIATION_ERROR: cond_met = ef[2];
				`COND_POSITION_ERROR: cond_met = ef[3];
				default: cond_met = 1'b0;
			endcase
		end
	endfunction

	// Two-stage synchroniser for input pins and error lines.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 8'h00;
			sync2_ff <= 8'h00;
		end else begin
			sync1_ff <= {err_position, err_deviation, err_alarm,
				err_timeout, shared_input_3, shared_input_2,
				shared_input_1, shared_input_0};
			sync2_ff <= sync1_ff;
		end
	end

	// =====================================================
	// Arithmetic helpers
	assign diff = {accum_ff[31], accum_ff} - {operand_ff[31], operand_ff};
	assign product = $signed(accum_ff) * $signed(operand_ff);

	seq_divider u_div (
		.pclk(pclk),
		.presetn(presetn),
		.start(div_start),
		.dividend(accum_ff),
		.divisor(operand_ff),
		.quotient_ff(div_quotient),
		.remainder_ff(div_remainder),
		.done_ff(div_done)
	);

	// Decodes and executes the pending command.
	always @* begin
		nxt_state = state_ff;
		nxt_accum = accum_ff;
		nxt_pc = pc_ff;
		nxt_reply_status = reply_status_ff;
		nxt_reply_value = reply_value_ff;
		nxt_cmp_flags = cmp_flags_ff;
		nxt_event = {`IRQ_WIDTH{1'b0}};
		div_start = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				nxt_state = ST_IDLE;
			end
			ST_EXEC: begin
				nxt_state = ST_IDLE;
				nxt_reply_status = `STATUS_OK;
				nxt_event[`IRQ_DONE] = 1'b1;
				if (standalone_ff)
					nxt_pc = pc_ff + 32'h00000001;
				if (code == `INSTR_INPUT_READ) begin
					if (bank == `BANK_DIGITAL)
						nxt_reply_value = {31'h00000000,
							sel_bit(sync2_ff[3:0], op_type)};
					else if (bank == `BANK_ANALOG)
						case (op_type[1:0])
							2'h0: nxt_reply_value = {16'h0000, adc_value_0};
							2'h1: nxt_reply_value = {16'h0000, adc_value_1};
							2'h2: nxt_reply_value = {16'h0000, adc_value_2};
							default: nxt_reply_value = {16'h0000, adc_value_3};
						endcase
					else if (bank == `BANK_OUTPUT)
						nxt_reply_value = {31'h00000000,
							sel_bit(outputs_ff, op_type)};
					else
						nxt_reply_status = `STATUS_BAD_VALUE;
					if (op_type > 8'h03)
						nxt_reply_status = `STATUS_BAD_TYPE;
					if (standalone_ff && nxt_reply_status == `STATUS_OK)
						nxt_accum = nxt_reply_value;
				end else if (code == `INSTR_ACCUM_ACCUM_INSTR_A) begin
					nxt_reply_value = operand_ff;
					case (op_type)
						`OP_ADD: nxt_accum = accum_ff + operand_ff;
						`OP_SUB: nxt_accum = accum_ff - operand_ff;
						`OP_MULTIPLY: nxt_accum = product[31:0];
						`OP_DIVIDE, `OP_REMAINDER: begin
							if (operand_ff == `RST_WORD) begin
								nxt_reply_status = `STATUS_BAD_VALUE;
							end else begin
								div_start = 1'b1;
								nxt_state = ST_DIV;
								nxt_event[`IRQ_DONE] = 1'b0;
							end
						end
						`OP_AND: nxt_accum = accum_ff & operand_ff;
						`OP_OR: nxt_accum = accum_ff | operand_ff;
						`OP_XOR: nxt_accum = accum_ff ^ operand_ff;
						`OP_INVERT: nxt_accum = ~accum_ff;
						`OP_LOAD: nxt_accum = operand_ff;
						default: nxt_reply_status = `STATUS_BAD_TYPE;
					endcase
				end else if (code == `INSTR_COMPARE) begin
					// Flags: zero, equal, greater, lower; accumulator kept.
					nxt_cmp_flags[0] = (diff[31:0] == `RST_WORD);
					nxt_cmp_flags[1] = (accum_ff == operand_ff);
					nxt_cmp_flags[2] = ~diff[32] & (diff[31:0] != `RST_WORD);
					nxt_cmp_flags[3] = diff[32];
				end else if (code == `INSTR_COND_JUMP) begin
					if (op_type > `COND_POSITION_ERROR)
						nxt_reply_status = `STATUS_BAD_TYPE;
					else if (cond_met(op_type, cmp_flags_ff, sync2_ff[7:4])) begin
						nxt_pc = operand_ff;
						nxt_event[`IRQ_JUMP] = 1'b1;
					end
				end else begin
					nxt_reply_status = `STATUS_BAD_CMD;
				end
				if (nxt_reply_status != `STATUS_OK)
					nxt_event[`IRQ_ERROR] = 1'b1;
			end
			ST_DIV: begin
				if (div_done) begin
					nxt_state = ST_IDLE;
					nxt_event[`IRQ_DONE] = 1'b1;
					if (op_type == `OP_DIVIDE)
						nxt_accum = div_quotient;
					else
						nxt_accum = div_remainder;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Command state and results; a command write while busy is dropped.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			cmd_ff <= `RST_WORD;
			accum_ff <= `RST_WORD;
			pc_ff <= `RST_WORD;
			reply_status_ff <= 8'h00;
			reply_value_ff <= `RST_WORD;
			cmp_flags_ff <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			accum_ff <= nxt_accum;
			pc_ff <= nxt_pc;
			reply_status_ff <= nxt_reply_status;
			reply_value_ff <= nxt_reply_value;
			cmp_flags_ff <= nxt_cmp_flags;
			if (wr_en && paddr == `OFS_CMD && state_ff == ST_IDLE) begin
				cmd_ff <= pwdata;
				state_ff <= ST_EXEC;
			end
		end
	end

	// Software-written configuration registers.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			operand_ff <= `RST_WORD;
			outputs_ff <= 4'h0;
			standalone_ff <= 1'b0;
			irq_enable_ff <= {`IRQ_WIDTH{1'b0}};
		end else if (wr_en) begin
			if (paddr == `OFS_OPERAND && state_ff == ST_IDLE)
				operand_ff <= pwdata;
			else if (paddr == `OFS_OUTPUTS)
				outputs_ff <= pwdata[3:0];
			else if (paddr == `OFS_CTRL)
				standalone_ff <= pwdata[0];
			else if (paddr == `OFS_IRQ_ENABLE)
				irq_enable_ff <= pwdata[`IRQ_WIDTH-1:0];
		end
	end

	// Sticky interrupt bits; a new event wins over a clear.
	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1) begin : g_irq
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					irq_status_ff[gi] <= 1'b0;
				else if (nxt_event[gi])
					irq_status_ff[gi] <= 1'b1;
				else if (wr_en && paddr == `OFS_IRQ_CLEAR && pwdata[gi])
					irq_status_ff[gi] <= 1'b0;
			end
		end
	endgenerate

	// Registered read data; unmapped offsets read as zero.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `RST_WORD;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == `OFS_CMD)
				prdata <= cmd_ff;
			else if (paddr == `OFS_OPERAND)
				prdata <= operand_ff;
			else if (paddr == `OFS_REPLY_STATUS)
				prdata <= {23'h000000, state_ff != ST_IDLE, reply_status_ff};
			else if (paddr == `OFS_REPLY_VALUE)
				prdata <= reply_value_ff;
			else if (paddr == `OFS_ACCUM)
				prdata <= accum_ff;
			else if (paddr == `OFS_PC)
				prdata <= pc_ff;
			else if (paddr == `OFS_FLAGS)
				prdata <= {24'h000000, sync2_ff[7:4], cmp_flags_ff};
			else if (paddr == `OFS_OUTPUTS)
				prdata <= {28'h0000000, outputs_ff};
			else if (paddr == `OFS_IRQ_STATUS)
				prdata <= {29'h00000000, irq_status_ff};
			else if (paddr == `OFS_IRQ_ENABLE)
				prdata <= {29'h00000000, irq_enable_ff};
			else if (paddr == `OFS_CTRL)
				prdata <= {31'h00000000, standalone_ff};
			else
				prdata <= `RST_WORD;
		end
	end

	// The read enable is kept for clarity of the access phase.
	wire unused_rd = rd_en;

endmodule // io_read_accumulator_branch_core
`default_nettype wire

// [tb/exec_core_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port-level checks of the execution core.
module exec_core_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic err_timeout,
	input wire logic err_alarm,
	input wire logic err_deviation,
	input wire logic err_position,
	input wire logic gp_output_0,
	input wire logic gp_output_1,
	input wire logic gp_output_2,
	input wire logic gp_output_3,
	input wire logic irq
);
	// Helper views of the bus phase and of grouped pins.
	wire logic [3:0] outs = {gp_output_3, gp_output_2, gp_output_1, gp_output_0};
	wire logic [3:0] errs = {err_position, err_deviation, err_alarm, err_timeout};
	wire logic [3:0] wd = pwdata[3:0];
	wire logic wr = psel && penable && pwrite;
	wire logic rd = psel && penable && !pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_OUT_FOLLOW: assert property (wr && paddr == 12'h01C |=> outs == $past(wd))
		else $error("output lines miss the written value");
	AST_OUT_HOLD: assert property (!(wr && paddr == 12'h01C) |=> $stable(outs))
		else $error("output lines moved without a write");
	AST_OUT_READ: assert property (rd && paddr == 12'h01C |-> prdata[3:0] == outs)
		else $error("output readback differs from pins");
	AST_IRQ_MASK: assert property (wr && paddr == 12'h028 && wd == 4'h0 |=> !irq)
		else $error("interrupt high while all sources masked");
	AST_UNMAPPED: assert property (rd && paddr >= 12'h030 |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	AST_NO_WAIT: assert property (psel && !penable ##1 penable |-> pready && !pslverr)
		else $error("access phase stalled or errored");
	AST_ERR_FLAGS: assert property (rd && paddr == 12'h018 && errs == $past(errs)
		&& errs == $past(errs, 2) && errs == $past(errs, 3) |-> prdata[7:4] == errs)
		else $error("error flags do not follow error lines");
	AST_STATUS_CODE: assert property (rd && paddr == 12'h008 && !prdata[8]
		|-> prdata[7:0] inside {8'h00, 8'h64, 8'h02, 8'h03, 8'h04})
		else $error("reply status code out of set");
endmodule // exec_core_asserts

bind io_read_accumulator_branch_core exec_core_asserts u_chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.err_timeout, .err_alarm, .err_deviation, .err_position, .gp_output_0,
	.gp_output_1, .gp_output_2, .gp_output_3, .irq);
`default_nettype wire

// [tb/io_field_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// Field side: input lines, converter words and error lines.
module io_field_model (
	input wire logic pclk,
	input wire logic refresh,
	output logic [3:0] lines,
	output logic [63:0] adc_bus,
	output logic [3:0] errs
);
	// Quiet levels until the first refresh.
	initial begin
		lines = 4'h0;
		adc_bus = 64'h0;
		errs = 4'h0;
	end
	// Each line gets an independent digital level and analog word.
	always @(posedge pclk) begin
		if (refresh) begin
			lines <= 4'($urandom);
			adc_bus <= {$urandom, $urandom};
			errs <= 4'($urandom);
		end
	end
endmodule // io_field_model
`default_nettype wire

// [tb/io_read_accumulator_branch_core_bench.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// Self-checking bench of the execution core.
module io_read_accumulator_branch_core_bench;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic refresh = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] q, op, acc_m, pc_m, wo, a, b, ja, ex;
	logic [63:0] e;
	logic [63:0] expq[$];
	wire [31:0] prdata;
	wire pready, pslverr, irq;
	wire [3:0] lines, errs, outs;
	wire [63:0] adc;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	// Clock of 40 ns period.
	always #20 pclk = ~pclk;
	io_field_model u_far (.pclk(pclk), .refresh(refresh), .lines(lines),
		.adc_bus(adc), .errs(errs));
	io_read_accumulator_branch_core u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.shared_input_0(lines[0]), .shared_input_1(lines[1]),
		.shared_input_2(lines[2]), .shared_input_3(lines[3]),
		.adc_value_0(adc[15:0]), .adc_value_1(adc[31:16]),
		.adc_value_2(adc[47:32]), .adc_value_3(adc[63:48]),
		.err_timeout(errs[0]), .err_alarm(errs[1]), .err_deviation(errs[2]),
		.err_position(errs[3]), .gp_output_0(outs[0]), .gp_output_1(outs[1]),
		.gp_output_2(outs[2]), .gp_output_3(outs[3]), .irq(irq));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input [31:0] seen, input [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input [11:0] ad, input w, input [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Read that notes the masked expectation for the monitor.
	task automatic rd(input [11:0] ad, input [31:0] m, input [31:0] x);
		expq.push_back({m, x & m});
		apb(ad, 0, 32'h0);
	endtask
	// Issue one command and poll the busy bit under a bound.
	task automatic cmd(input [7:0] c, input [7:0] t, input [7:0] bk,
		input [31:0] v);
		int k;
		apb(12'h004, 1, v);
		apb(12'h000, 1, {8'h00, bk, t, c});
		k = 0;
		q = 32'h100;
		while (q[8] && k < 60) begin
			rd(12'h008, 32'h0, 32'h0);
			k++;
		end
		if (q[8]) begin
			n_fail++;
		end
	endtask
	function automatic [31:0] accum_instr_a(input [31:0] x, input [3:0] t, input [31:0] y);
		case (t)
		0: accum_instr_a = x + y;
		1: accum_instr_a = x - y;
		2: accum_instr_a = x * y;
		3: accum_instr_a = $signed(x) / $signed(y);
		4: accum_instr_a = $signed(x) % $signed(y);
		5: accum_instr_a = x & y;
		6: accum_instr_a = x | y;
		7: accum_instr_a = x ^ y;
		8: accum_instr_a = ~x;
		default: accum_instr_a = y;
		endcase
	endfunction
	function automatic bit taken(input [3:0] c, input [31:0] x, input [31:0] y,
		input [3:0] er);
		case (c)
		0, 2: taken = x == y;
		1, 3: taken = x != y;
		4: taken = $signed(x) > $signed(y);
		5: taken = $signed(x) >= $signed(y);
		6: taken = $signed(x) < $signed(y);
		7: taken = $signed(x) <= $signed(y);
		default: taken = er[c - 4'h8];
		endcase
	endfunction
	task automatic new_field();
		refresh <= 1;
		@(posedge pclk);
		refresh <= 0;
		repeat (4) @(posedge pclk);
	endtask
	// Monitor: each read result pops the oldest note and is compared with it when its mask is nonzero.
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0) begin
			e = expq.pop_front();
			if (e[63:32] != 0) begin
				chk(prdata & e[63:32], e[31:0]);
			end
		end
	end
	// Cycle ceiling against a hang.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		q = $urandom(32'h3E8919F3);
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(12'h010, '1, 32'h0);
		rd(12'h014, '1, 32'h0);
		rd(12'h020, '1, 32'h0);
		rd(12'h0FC, '1, 32'h0);
		apb(12'h028, 1, 32'h7);
		acc_m = 0;
		for (int t = 0; t < 10; t++) begin
			op = $urandom;
			if (t == 3 || t == 4) begin
				op = op % 1000 + 1;
			end
			cmd(8'h13, t[7:0], 8'($urandom), op);
			acc_m = accum_instr_a(acc_m, t[3:0], op);
			rd(12'h008, 32'hFF, 32'h64);
			rd(12'h00C, '1, op);
			rd(12'h010, '1, acc_m);
		end
		cmd(8'h13, 8'h03, 8'h00, 32'h0);
		rd(12'h008, 32'hFF, 32'h04);
		rd(12'h010, '1, acc_m);
		rd(12'h020, 32'h2, 32'h2);
		chk({31'h0, irq}, 32'h1);
		apb(12'h028, 1, 32'h0);
		wo = $urandom;
		apb(12'h01C, 1, wo);
		chk({28'h0, outs}, {28'h0, wo[3:0]});
		rd(12'h01C, 32'hF, wo);
		chk({31'h0, irq}, 32'h0);
		apb(12'h028, 1, 32'h7);
		chk({31'h0, irq}, 32'h1);
		apb(12'h024, 1, 32'h7);
		chk({31'h0, irq}, 32'h0);
		cmd(8'h0F, 8'h04, 8'h00, 32'h0);
		rd(12'h008, 32'hFF, 32'h03);
		cmd(8'h0F, 8'h00, 8'h03, 32'h0);
		rd(12'h008, 32'hFF, 32'h04);
		new_field();
		for (int p = 0; p < 4; p++) begin
			for (int bk = 0; bk < 3; bk++) begin
				cmd(8'h0F, p[7:0], bk[7:0], 32'h0);
				ex = bk == 0 ? 32'(lines[p]) : bk == 1 ? 32'(adc[16*p+:16]) : 32'(wo[p]);
				rd(12'h00C, '1, ex);
				rd(12'h010, '1, acc_m);
			end
		end
		apb(12'h02C, 1, 32'h1);
		cmd(8'h0F, 8'h02, 8'h01, 32'h0);
		acc_m = 32'(adc[47:32]);
		pc_m = 1;
		rd(12'h010, '1, acc_m);
		for (int c = 0; c < 12; c++) begin
			new_field();
			a = $urandom_range(0, 2) - 1;
			b = $urandom_range(0, 2) - 1;
			ja = $urandom_range(0, 255);
			cmd(8'h13, 8'h09, 8'h00, a);
			cmd(8'h14, 8'h00, 8'h00, b);
			rd(12'h010, '1, a);
			rd(12'h018, 32'hFF, {24'h0, errs, taken(4'h6, a, b, errs),
				taken(4'h4, a, b, errs), taken(4'h2, a, b, errs),
				taken(4'h0, a, b, errs)});
			cmd(8'h15, c[7:0], 8'h00, ja);
			pc_m = taken(c[3:0], a, b, errs) ? ja : pc_m + 3;
			rd(12'h014, '1, pc_m);
		end
		end_of_test();
	end
endmodule // io_read_accumulator_branch_core_bench
`default_nettype wire
